//--- rtl/csb_pkg.sv
// constants for the compare / skip / branch execution block
// assumes a 16-bit instruction word and a 16-bit word-addressed program counter
package csb_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned PC_W    = 16;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned CNT_W   = 2;

    // ------------------------------------------------------------
    // opcode matching: (word & mask) == pattern
    // ------------------------------------------------------------
    localparam logic [15:0] CMP_IMM_MASK      = 16'hf000;
    localparam logic [15:0] CMP_IMM_PAT       = 16'h3000;
    localparam logic [15:0] SKIP_REG_MASK     = 16'hfe08;
    localparam logic [15:0] SKIP_REG_CLR_PAT  = 16'hfc00;
    localparam logic [15:0] SKIP_REG_SET_PAT  = 16'hfe00;
    localparam logic [15:0] SKIP_IO_MASK      = 16'hff00;
    localparam logic [15:0] SKIP_IO_CLR_PAT   = 16'h9900;
    localparam logic [15:0] SKIP_IO_SET_PAT   = 16'h9b00;
    localparam logic [15:0] BRANCH_MASK       = 16'hfc00;
    localparam logic [15:0] BRANCH_SET_PAT    = 16'hf000;
    localparam logic [15:0] BRANCH_CLR_PAT    = 16'hf400;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_SEL_LSB   = 0;
    localparam int unsigned BIT_SEL_W     = 3;
    localparam int unsigned OFFSET_LSB    = 3;
    localparam int unsigned OFFSET_W      = 7;
    localparam int unsigned IMM_HI_LSB    = 8;
    localparam int unsigned IMM_LO_LSB    = 0;
    localparam int unsigned IMM_NIB_W     = 4;

    // ------------------------------------------------------------
    // status_flags bit positions
    // ------------------------------------------------------------
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_H = 5;
    localparam logic [7:0]  CMP_FLAG_MASK = 8'h2f;

    // ------------------------------------------------------------
    // pc steps, cycle counts (extra cycles beyond the first) and reset values
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0]  PC_STEP_NEXT    = 16'h0001;
    localparam logic [PC_W-1:0]  PC_STEP_SKIP1   = 16'h0002;
    localparam logic [PC_W-1:0]  PC_STEP_SKIP2   = 16'h0003;
    localparam logic [CNT_W-1:0] EXTRA_NONE      = 2'h0;
    localparam logic [CNT_W-1:0] EXTRA_ONE       = 2'h1;
    localparam logic [CNT_W-1:0] EXTRA_TWO       = 2'h2;
    localparam logic [PC_W-1:0]  PC_RESET        = 16'h0000;
    localparam logic [7:0]       FLAGS_RESET     = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_CMP_IMM,
        OP_SKIP_REG_CLR,
        OP_SKIP_REG_SET,
        OP_SKIP_IO_CLR,
        OP_SKIP_IO_SET,
        OP_BRANCH_SET,
        OP_BRANCH_CLR
    } csb_op_t;

    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } csb_state_t;

endpackage

//--- rtl/csb_cmp_flags.sv
// subtract-and-flag unit for compare against an immediate
// assumes operands are stable for the cycle in which the result is used
`timescale 1ns/10ps
module csb_cmp_flags
    import csb_pkg::*;
(
    input  wire logic [csb_pkg::DATA_W-1:0] rd_val,
    input  wire logic [csb_pkg::DATA_W-1:0] imm_val,
    input  wire logic [7:0]                 flags_in,
    output logic      [7:0]                 flags_out
);

    import csb_pkg::*;

    logic [DATA_W-1:0] diff;

    // difference is only used for flags and never written back
    always_comb begin
        diff      = rd_val - imm_val;
        flags_out = flags_in;
        flags_out[FLAG_Z] = (diff == 8'h00);
        flags_out[FLAG_N] = diff[7];
        flags_out[FLAG_V] = (rd_val[7] & ~imm_val[7] & ~diff[7])
                          | (~rd_val[7] & imm_val[7] & diff[7]);
        flags_out[FLAG_C] = (~rd_val[7] & imm_val[7]) | (imm_val[7] & diff[7])
                          | (diff[7] & ~rd_val[7]);
        flags_out[FLAG_H] = (~rd_val[3] & imm_val[3]) | (imm_val[3] & diff[3])
                          | (diff[3] & ~rd_val[3]);
    end

endmodule

//--- rtl/csb_exec.sv
// execution of compare-immediate, bit skips and flag branches
// assumes decode presents the word with its operand data in the same cycle
//
// Behaviour
// RULE1: compare immediate updates Z N V C H only
// RULE2: register bit clear skips next instruction
// RULE3: register bit set skips next instruction
// RULE4: io bit clear skips, flags untouched
// RULE5: io bit set skips, flags untouched
// RULE6: flag set branches to pc plus k plus one
// RULE7: flag clear branches likewise, flags untouched
// RULE8: carry clear takes the relative branch
// RULE9: carry set takes the relative branch
// RULE10: same-or-higher equals carry clear branch
`timescale 1ns/10ps
module csb_exec
    import csb_pkg::*;
(
    input  wire logic                        CLK,
    input  wire logic                        RST,
    input  wire logic                        INSTR_VALID,
    input  wire logic [csb_pkg::INSTR_W-1:0] INSTR,
    input  wire logic                        NEXT_TWO_WORD,
    input  wire logic [csb_pkg::PC_W-1:0]    PC,
    input  wire logic [csb_pkg::DATA_W-1:0]  REG_DATA,
    input  wire logic [csb_pkg::DATA_W-1:0]  IO_DATA,
    input  wire logic [7:0]                  FLAGS_IN,
    output logic                             INSTR_READY,
    output logic                             DONE,
    output logic                             PC_LOAD,
    output logic      [csb_pkg::PC_W-1:0]    PC_NEXT,
    output logic                             FLAGS_WE,
    output logic      [7:0]                  FLAGS_OUT
);

    import csb_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic csb_op_t decode_op(input logic [INSTR_W-1:0] w);
        csb_op_t op;
        op = OP_NONE;
        if ((w & CMP_IMM_MASK) == CMP_IMM_PAT)
            op = OP_CMP_IMM;
        else if ((w & SKIP_REG_MASK) == SKIP_REG_CLR_PAT)
            op = OP_SKIP_REG_CLR;
        else if ((w & SKIP_REG_MASK) == SKIP_REG_SET_PAT)
            op = OP_SKIP_REG_SET;
        else if ((w & SKIP_IO_MASK) == SKIP_IO_CLR_PAT)
            op = OP_SKIP_IO_CLR;
        else if ((w & SKIP_IO_MASK) == SKIP_IO_SET_PAT)
            op = OP_SKIP_IO_SET;
        else if ((w & BRANCH_MASK) == BRANCH_SET_PAT)
            op = OP_BRANCH_SET;
        else if ((w & BRANCH_MASK) == BRANCH_CLR_PAT)
            op = OP_BRANCH_CLR;
        return op;
    endfunction

    function automatic logic pick_bit(input logic [7:0] v,
                                      input logic [INSTR_W-1:0] w);
        logic [BIT_SEL_W-1:0] sel;
        sel = w[BIT_SEL_LSB +: BIT_SEL_W];
        return v[sel];
    endfunction

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                   input logic [INSTR_W-1:0] w);
        logic [OFFSET_W-1:0] k;
        logic [PC_W-1:0]     k_ext;
        k     = w[OFFSET_LSB +: OFFSET_W];
        k_ext = {{(PC_W-OFFSET_W){k[OFFSET_W-1]}}, k};
        return pc + k_ext + PC_STEP_NEXT;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        csb_state_t       state;
        logic [CNT_W-1:0] extra;
        logic             taken;
        logic [PC_W-1:0]  pc_next;
        logic             flags_we;
        logic [7:0]       flags;
    } csb_regs_t;

    csb_regs_t         r_q;
    csb_regs_t         r_d;
    csb_op_t           op;
    logic              accept;
    logic              finish;
    logic [DATA_W-1:0] imm_val;
    logic [7:0]        cmp_flags;
    logic              cond;

    assign op      = decode_op(INSTR);
    assign imm_val = {INSTR[IMM_HI_LSB +: IMM_NIB_W], INSTR[IMM_LO_LSB +: IMM_NIB_W]};

    csb_cmp_flags u_cmp (
        .rd_val    (REG_DATA),
        .imm_val   (imm_val),
        .flags_in  (FLAGS_IN),
        .flags_out (cmp_flags)
    );

    // ------------------------------------------------------------
    // handshake: a new word is taken while idle or in the last cycle
    // ------------------------------------------------------------
    assign finish      = (r_q.state == ST_EXEC) && (r_q.extra == EXTRA_NONE);
    assign INSTR_READY = (r_q.state == ST_IDLE) || finish;
    assign accept      = INSTR_VALID && INSTR_READY;
    assign DONE        = finish;
    assign PC_LOAD     = finish && r_q.taken;
    assign PC_NEXT     = r_q.pc_next;
    assign FLAGS_WE    = finish && r_q.flags_we;
    assign FLAGS_OUT   = r_q.flags;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_d  = r_q;
        cond = 1'b0;
        if (r_q.state == ST_EXEC && r_q.extra != EXTRA_NONE) begin
            r_d.extra = r_q.extra - EXTRA_ONE;
        end else if (finish) begin
            r_d.state = ST_IDLE;
        end
        if (accept) begin
            r_d.state    = ST_EXEC;
            r_d.extra    = EXTRA_NONE;
            r_d.taken    = 1'b0;
            r_d.pc_next  = PC + PC_STEP_NEXT;
            r_d.flags_we = 1'b0;
            r_d.flags    = FLAGS_IN;
            unique case (op)
                OP_CMP_IMM: begin
                    // only the compare flags change, no result is stored
                    r_d.flags    = (cmp_flags & CMP_FLAG_MASK)
                                 | (FLAGS_IN & ~CMP_FLAG_MASK);    // [RULE1]
                    r_d.flags_we = 1'b1;                          // [RULE1]
                end
                OP_SKIP_REG_CLR: cond = ~pick_bit(REG_DATA, INSTR); // [RULE2]
                OP_SKIP_REG_SET: cond = pick_bit(REG_DATA, INSTR);  // [RULE3]
                OP_SKIP_IO_CLR:  cond = ~pick_bit(IO_DATA, INSTR);  // [RULE4]
                OP_SKIP_IO_SET:  cond = pick_bit(IO_DATA, INSTR);   // [RULE5]
                // carry tests are flag index zero of these two forms
                OP_BRANCH_SET:   cond = pick_bit(FLAGS_IN, INSTR);  // [RULE6] [RULE9]
                OP_BRANCH_CLR:   cond = ~pick_bit(FLAGS_IN, INSTR); // [RULE7] [RULE8] [RULE10]
                OP_NONE:         cond = 1'b0;
            endcase
            if (cond) begin
                r_d.taken = 1'b1;
                if (op == OP_BRANCH_SET || op == OP_BRANCH_CLR) begin
                    r_d.pc_next = rel_target(PC, INSTR);          // [RULE6] [RULE7]
                    r_d.extra   = EXTRA_ONE;                      // [RULE6]
                end else if (NEXT_TWO_WORD) begin
                    r_d.pc_next = PC + PC_STEP_SKIP2;             // [RULE2]
                    r_d.extra   = EXTRA_TWO;                      // [RULE2]
                end else begin
                    r_d.pc_next = PC + PC_STEP_SKIP1;             // [RULE2]
                    r_d.extra   = EXTRA_ONE;                      // [RULE2]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_q.state    <= ST_IDLE;
            r_q.extra    <= EXTRA_NONE;
            r_q.taken    <= 1'b0;
            r_q.pc_next  <= PC_RESET;
            r_q.flags_we <= 1'b0;
            r_q.flags    <= FLAGS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

endmodule

//--- dv/csb_exec_sva.sv
// port checker for the compare / skip / branch execution block
// bound onto csb_exec from the bench top file; sees only its ports
`timescale 1ns/10ps
module csb_exec_sva
    import csb_pkg::*;
(
    input wire logic                        CLK,
    input wire logic                        RST,
    input wire logic                        INSTR_VALID,
    input wire logic [csb_pkg::INSTR_W-1:0] INSTR,
    input wire logic                        NEXT_TWO_WORD,
    input wire logic [csb_pkg::PC_W-1:0]    PC,
    input wire logic [csb_pkg::DATA_W-1:0]  REG_DATA,
    input wire logic [csb_pkg::DATA_W-1:0]  IO_DATA,
    input wire logic [7:0]                  FLAGS_IN,
    input wire logic                        INSTR_READY,
    input wire logic                        DONE,
    input wire logic                        PC_LOAD,
    input wire logic [csb_pkg::PC_W-1:0]    PC_NEXT,
    input wire logic                        FLAGS_WE,
    input wire logic [7:0]                  FLAGS_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // decode of the offered word
    // ------------------------------------------------------------
    wire       acc  = INSTR_VALID & INSTR_READY;
    wire [2:0] b    = INSTR[2:0];
    wire       cmp  = (INSTR & CMP_IMM_MASK) == CMP_IMM_PAT;
    wire       rclr = (INSTR & SKIP_REG_MASK) == SKIP_REG_CLR_PAT && !REG_DATA[b];
    wire       rset = (INSTR & SKIP_REG_MASK) == SKIP_REG_SET_PAT && REG_DATA[b];
    wire       iot  = ((INSTR & SKIP_IO_MASK) == SKIP_IO_CLR_PAT && !IO_DATA[b])
                   || ((INSTR & SKIP_IO_MASK) == SKIP_IO_SET_PAT && IO_DATA[b]);
    wire       bs   = (INSTR & BRANCH_MASK) == BRANCH_SET_PAT;
    wire       bc   = (INSTR & BRANCH_MASK) == BRANCH_CLR_PAT;
    wire [15:0] tgt = PC + {{9{INSTR[9]}}, INSTR[9:3]} + 16'h0001;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_taken2;
        ##1 (!DONE && !INSTR_READY) ##1 (DONE && PC_LOAD);
    endsequence
    a_cmp_flag_write: assert property (acc && cmp |=> DONE && FLAGS_WE && !PC_LOAD
        && FLAGS_OUT[7:6] == $past(FLAGS_IN[7:6]) && FLAGS_OUT[4] == $past(FLAGS_IN[4]))
        else $error("compare flag update wrong");
    a_cmp_equal_zero: assert property (acc && cmp && REG_DATA == {INSTR[11:8], INSTR[3:0]}
        |=> FLAGS_OUT[FLAG_Z] && !FLAGS_OUT[FLAG_C]) else $error("compare of equal values wrong");
    a_rclr_skip: assert property (acc && rclr && !NEXT_TWO_WORD
        |-> s_taken2 ##0 PC_NEXT == $past(PC, 2) + 16'h0002) else $error("bit clear skip wrong");
    a_rset_long_skip: assert property (acc && rset && NEXT_TWO_WORD |-> ##1 !DONE [*2]
        ##1 DONE && PC_LOAD && PC_NEXT == $past(PC, 3) + 16'h0003) else $error("long skip wrong");
    a_io_skip_flags: assert property (acc && iot && !NEXT_TWO_WORD
        |-> s_taken2 ##0 !FLAGS_WE && !$past(FLAGS_WE)) else $error("io skip wrong");
    a_bset_jump: assert property (acc && bs && FLAGS_IN[b]
        |-> s_taken2 ##0 PC_NEXT == $past(tgt, 2)) else $error("flag set branch wrong");
    a_bclr_jump: assert property (acc && bc && !FLAGS_IN[b]
        |-> s_taken2 ##0 PC_NEXT == $past(tgt, 2) && !FLAGS_WE) else $error("flag clear branch wrong");
    a_branch_fall: assert property (acc && ((bs && !FLAGS_IN[b]) || (bc && FLAGS_IN[b]))
        |=> DONE && !PC_LOAD && !FLAGS_WE && PC_NEXT == $past(PC) + 16'h0001)
        else $error("untaken branch wrong");
endmodule

//--- dv/tb_top.sv
// self-checking bench for csb_exec
// drives the decode side directly; the checker is bound below
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import csb_pkg::*;
    logic CLK = 0, RST = 1, VLD = 0, NTW = 0, RDY, DONE, LD, WE;
    logic [15:0] INS = 0, PC = 0, PCN;
    logic [7:0]  RD = 0, IO = 0, FI = 0, FO;
    int          errors = 0, tests_run = 0;
    always #25 CLK = ~CLK;
    csb_exec dut (.CLK(CLK), .RST(RST), .INSTR_VALID(VLD), .INSTR(INS), .NEXT_TWO_WORD(NTW),
        .PC(PC), .REG_DATA(RD), .IO_DATA(IO), .FLAGS_IN(FI), .INSTR_READY(RDY), .DONE(DONE),
        .PC_LOAD(LD), .PC_NEXT(PCN), .FLAGS_WE(WE), .FLAGS_OUT(FO));
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // offer one word, then judge length, pc and flags at the done cycle
    task automatic op(input logic [15:0] w, p, input logic [7:0] r, i, f, input logic t,
                      input logic [2:0] n, input logic l, input logic [15:0] ep,
                      input logic we, input logic [7:0] ef);
        logic [2:0] c;
        c = 0;
        @(posedge CLK);
        VLD <= 1; INS <= w; PC <= p; RD <= r; IO <= i; FI <= f; NTW <= t;
        @(negedge CLK);
        while (RDY !== 1'b1 && c < 7) begin @(negedge CLK); c++; end
        if (c == 7) begin errors++; close_out(); end
        @(posedge CLK);
        VLD <= 0;
        c = 0;
        do begin @(negedge CLK); c++; end while (DONE !== 1'b1 && c < 5);
        if (DONE !== 1'b1) begin errors++; close_out(); end
        `CHK(c, n)
        `CHK(DONE, 1'b1)
        `CHK(LD, l)
        `CHK(PCN, ep)
        `CHK(WE, we)
        `CHK(FO, ef)
    endtask
    // expected compare flags from plain arithmetic: borrows and signed range
    function automatic logic [7:0] cmpf(input logic [7:0] f, a, k);
        logic [7:0] d;
        int         sd;
        d  = a - k;
        sd = $signed(a) - $signed(k);
        cmpf = f;
        cmpf[FLAG_C] = (a < k);
        cmpf[FLAG_H] = (a[3:0] < k[3:0]);
        cmpf[FLAG_V] = (sd > 127) || (sd < -128);
        cmpf[FLAG_N] = d[7];
        cmpf[FLAG_Z] = (d == 8'h00);
    endfunction
    task automatic t_cmp();
        logic [7:0] a[4] = '{8'h10, 8'h00, 8'h80, 8'h3c};
        logic [7:0] k[4] = '{8'h10, 8'h01, 8'h01, 8'h0d};
        for (int j = 0; j < 4; j++)
            op(CMP_IMM_PAT | {4'h0, k[j][7:4], 4'h0, k[j][3:0]}, 16'h0040, a[j], 8'h00, 8'hd0,
               0, 1, 0, 16'h0041, 1, cmpf(8'hd0, a[j], k[j]));
        $display("test compare done");
    endtask
    task automatic t_skip();
        for (logic [15:0] b = 16'h0000; b < 16'h0008; b += 16'h0007) begin
            op(SKIP_REG_CLR_PAT | 16'h0050 | b, 16'h0200, ~(8'h01 << b), 0, 0, 0, 2, 1, 16'h0202, 0, 0);
            op(SKIP_REG_CLR_PAT | 16'h0050 | b, 16'h0200, ~(8'h01 << b), 0, 0, 1, 3, 1, 16'h0203, 0, 0);
            op(SKIP_REG_CLR_PAT | 16'h0050 | b, 16'h0200, 8'h01 << b, 0, 0, 1, 1, 0, 16'h0201, 0, 0);
            op(SKIP_REG_SET_PAT | 16'h0050 | b, 16'hfffe, 8'h01 << b, 0, 0, 1, 3, 1, 16'h0001, 0, 0);
            op(SKIP_REG_SET_PAT | 16'h0050 | b, 16'h0300, ~(8'h01 << b), 0, 0, 0, 1, 0, 16'h0301, 0, 0);
            op(SKIP_IO_CLR_PAT | 16'h0028 | b, 16'h0400, 0, ~(8'h01 << b), 8'h2f, 0, 2, 1, 16'h0402, 0, 8'h2f);
            op(SKIP_IO_CLR_PAT | 16'h0028 | b, 16'h0400, 0, 8'h01 << b, 8'h2f, 0, 1, 0, 16'h0401, 0, 8'h2f);
            op(SKIP_IO_SET_PAT | 16'h0028 | b, 16'h0500, 0, 8'h01 << b, 8'h2f, 1, 3, 1, 16'h0503, 0, 8'h2f);
            op(SKIP_IO_SET_PAT | 16'h0028 | b, 16'h0500, 0, ~(8'h01 << b), 8'h2f, 0, 1, 0, 16'h0501, 0, 8'h2f);
        end
        $display("test skips done");
    endtask
    task automatic t_branch();
        logic [7:0] m;
        for (logic [15:0] s = 16'h0000; s < 16'h0008; s++) begin
            m = 8'h01 << s;
            op(BRANCH_SET_PAT | 16'h0200 | s, 16'h0010, 0, 0, m, 0, 2, 1, 16'hffd1, 0, m);
            op(BRANCH_SET_PAT | 16'h0200 | s, 16'h0010, 0, 0, ~m, 0, 1, 0, 16'h0011, 0, ~m);
            op(BRANCH_CLR_PAT | 16'h01f8 | s, 16'h0100, 0, 0, ~m, 0, 2, 1, 16'h0140, 0, ~m);
            op(BRANCH_CLR_PAT | 16'h01f8 | s, 16'h0100, 0, 0, m, 0, 1, 0, 16'h0101, 0, m);
        end
        op(16'h0000, 16'hffff, 0, 0, 8'h81, 0, 1, 0, 16'h0000, 0, 8'h81);
        $display("test branches done");
    endtask
    // taken branch with a compare waiting: the compare goes in at the done edge
    task automatic t_b2b();
        @(posedge CLK);
        VLD <= 1; INS <= BRANCH_SET_PAT | 16'h0008; PC <= 16'h0700; FI <= 8'h01;
        @(posedge CLK);
        INS <= CMP_IMM_PAT; RD <= 8'h00;
        @(negedge CLK);
        `CHK({DONE, RDY}, 2'b00)
        @(negedge CLK);
        `CHK({DONE, LD, PCN}, {2'b11, 16'h0702})
        @(posedge CLK);
        VLD <= 0;
        @(negedge CLK);
        `CHK({DONE, WE, LD, PCN, FO}, {3'b110, 16'h0701, cmpf(8'h01, 8'h00, 8'h00)})
        $display("test back to back done");
    endtask
    // reset in the middle of a long skip, then a normal skip afterwards
    task automatic t_reset();
        @(posedge CLK);
        VLD <= 1; INS <= SKIP_IO_SET_PAT; PC <= 16'h0600; IO <= 8'h01; NTW <= 1;
        @(posedge CLK);
        VLD <= 0; RST <= 1;
        @(negedge CLK);
        `CHK({RDY, DONE, LD, WE, PCN, FO}, {4'b1000, PC_RESET, FLAGS_RESET}) // reset state
        @(posedge CLK);
        RST <= 0;
        op(SKIP_REG_SET_PAT, 16'h0800, 8'h01, 0, 0, 0, 2, 1, 16'h0802, 0, 0);
        $display("test reset done");
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 0;
        t_cmp();
        t_skip();
        t_branch();
        t_b2b();
        t_reset();
        close_out();
    end
endmodule
bind csb_exec csb_exec_sva u_sva (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .NEXT_TWO_WORD(NEXT_TWO_WORD), .PC(PC), .REG_DATA(REG_DATA),
    .IO_DATA(IO_DATA), .FLAGS_IN(FLAGS_IN), .INSTR_READY(INSTR_READY), .DONE(DONE),
    .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .FLAGS_WE(FLAGS_WE), .FLAGS_OUT(FLAGS_OUT));
